// ==== inc/ieb_cfg.svh ====
// Register offsets, field positions, reset values and bus codes for the interrupt enable bank.
`ifndef IEB_CFG_SVH
`define IEB_CFG_SVH

`define IEB_ADDR_W      8
`define IEB_OFF_EN      8'h00
`define IEB_SPAN_EN     8'h0c
`define IEB_OFF_FLAG    8'h10
`define IEB_SPAN_FLAG   8'h0c
`define IEB_OFF_PRIO    8'h20
`define IEB_SPAN_PRIO   8'h30
`define IEB_OFF_STATUS  8'h50
`define IEB_OFF_MASK    8'h54

`define IEB_IMPL_G0     16'h3fef
`define IEB_IMPL_G1     16'hfedf
`define IEB_IMPL_G2     16'h3fe3

`define IEB_EN_RST      16'h0000
`define IEB_FLAG_RST    16'h0000
`define IEB_PRIO_RST    3'h4
`define IEB_PRIO_OFF    3'h0
`define IEB_STATUS_RST  4'h0
`define IEB_MASK_RST    4'h0

`define IEB_ST_BADADDR  3

`define IEB_POS_ADC_DONE      13
`define IEB_POS_EXT_PIN_A     0
`define IEB_POS_UART_B_TX     15
`define IEB_POS_CAPTURE_H     7
`define IEB_POS_PARALLEL_PORT 13
`define IEB_POS_SPI_B_FAULT   0

`define IEB_RESP_OKAY   2'h0
`define IEB_RESP_SLVERR 2'h2

`endif

// ==== inc/ieb_pkg.sv ====
// Types shared by the interrupt enable bank modules.
package ieb_pkg;

    // Group zero layout, bit 15 first.
    typedef struct packed {
        logic rsvd0_15, rsvd0_14, adc_done_en, uart_a_tx_en, uart_a_rx_en, spi_a_xfer_en, spi_a_fault_en;
        logic timer_c_en, timer_b_en, compare_b_en, capture_b_en, rsvd0_4, timer_a_en, compare_a_en;
        logic capture_a_en, ext_pin_a_en;
    } ieb_g0_t;

    // Group one layout, bit 15 first.
    typedef struct packed {
        logic uart_b_tx_en, uart_b_rx_en, ext_pin_c_en, timer_e_en, timer_d_en, compare_d_en, compare_c_en;
        logic rsvd1_8, capture_h_en, capture_g_en, rsvd1_5, ext_pin_b_en, pin_change_en, comparator_en;
        logic i2c_a_master_en, i2c_a_slave_en;
    } ieb_g1_t;

    // Group two layout, bit 15 first.
    typedef struct packed {
        logic rsvd2_15, rsvd2_14, parallel_port_en, compare_h_en, compare_g_en, compare_f_en, compare_e_en;
        logic capture_f_en, capture_e_en, capture_d_en, capture_c_en, rsvd2_4, rsvd2_3, rsvd2_2;
        logic spi_b_event_en, spi_b_fault_en;
    } ieb_g2_t;

    typedef enum logic [2:0] {SEL_NONE, SEL_EN, SEL_FLAG, SEL_PRIO, SEL_STATUS, SEL_MASK} ieb_kind_t;
    typedef struct packed {
        ieb_kind_t  kind;
        logic [3:0] idx;
    } ieb_sel_t;

    typedef struct packed {
        logic        valid;
        logic [7:0]  addr;
        logic [31:0] data;
        logic [3:0]  strb;
    } ieb_wr_t;

    typedef struct packed {
        logic       valid;
        logic [7:0] addr;
    } ieb_rd_t;

    typedef enum logic {WR_IDLE, WR_RESP} ieb_wst_t;
    typedef enum logic {RD_IDLE, RD_RESP} ieb_rst_t;

    typedef struct packed {
        ieb_wst_t    wst;
        ieb_rst_t    rst;
        logic        aw_have;
        logic [7:0]  aw_addr;
        logic        w_have;
        logic [31:0] w_data;
        logic [3:0]  w_strb;
        logic [1:0]  bresp;
        logic [31:0] rdata;
        logic [1:0]  rresp;
    } ieb_axs_t;

    typedef struct packed {
        logic [2:0][15:0] en;
        logic [2:0][15:0] flag;
        logic [2:0][15:0] req;
        logic [47:0][2:0] prio;
        logic [2:0]       prio_top;
        logic [3:0]       status;
        logic [3:0]       mask;
        logic [2:0]       grp_prev;
    } ieb_core_t;

endpackage

// ==== logic/ieb_axil_slave.sv ====
// AXI4-Lite slave front end that turns bus transfers into one-cycle register requests.
`timescale 1ns/1ps
`default_nettype none
`include "ieb_cfg.svh"
module ieb_axil_slave (
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic        awvalid,
    output logic             awready,
    input  wire logic [7:0]  awaddr,
    input  wire logic        wvalid,
    output logic             wready,
    input  wire logic [31:0] wdata,
    input  wire logic [3:0]  wstrb,
    output logic             bvalid,
    input  wire logic        bready,
    output logic [1:0]       bresp,
    input  wire logic        arvalid,
    output logic             arready,
    input  wire logic [7:0]  araddr,
    output logic             rvalid,
    input  wire logic        rready,
    output logic [31:0]      rdata,
    output logic [1:0]       rresp,
    output ieb_pkg::ieb_wr_t wr_req,
    input  wire logic        wr_err,
    output ieb_pkg::ieb_rd_t rd_req,
    input  wire logic [31:0] rd_data,
    input  wire logic        rd_err
);
    ieb_pkg::ieb_axs_t s;
    ieb_pkg::ieb_axs_t n;

    // Address and data are caught separately so the master may offer them in either order.
    assign awready = !s.aw_have && (s.wst == ieb_pkg::WR_IDLE);
    assign wready  = !s.w_have && (s.wst == ieb_pkg::WR_IDLE);
    assign bvalid  = (s.wst == ieb_pkg::WR_RESP);
    assign bresp   = s.bresp;
    assign arready = (s.rst == ieb_pkg::RD_IDLE);
    assign rvalid  = (s.rst == ieb_pkg::RD_RESP);
    assign rdata   = s.rdata;
    assign rresp   = s.rresp;

    // The write is issued only from registered halves, so its address and data never glitch.
    assign wr_req.valid = s.aw_have && s.w_have && (s.wst == ieb_pkg::WR_IDLE);
    assign wr_req.addr  = s.aw_addr;
    assign wr_req.data  = s.w_data;
    assign wr_req.strb  = s.w_strb;
    assign rd_req.valid = arvalid && arready;
    assign rd_req.addr  = araddr;

    // Next state of both channels.
    always_comb begin
        n = s;
        if (awvalid && awready) begin
            n.aw_have = 1'b1;
            n.aw_addr = awaddr;
        end
        if (wvalid && wready) begin
            n.w_have = 1'b1;
            n.w_data = wdata;
            n.w_strb = wstrb;
        end
        case (s.wst)
            ieb_pkg::WR_IDLE: begin
                if (wr_req.valid) begin
                    n.aw_have = 1'b0;
                    n.w_have  = 1'b0;
                    n.bresp   = wr_err ? `IEB_RESP_SLVERR : `IEB_RESP_OKAY;
                    n.wst     = ieb_pkg::WR_RESP;
                end
            end
            ieb_pkg::WR_RESP: begin
                if (bready) begin
                    n.wst = ieb_pkg::WR_IDLE;
                end
            end
            default: n.wst = ieb_pkg::WR_IDLE;
        endcase
        case (s.rst)
            ieb_pkg::RD_IDLE: begin
                if (rd_req.valid) begin
                    n.rdata = rd_data;
                    n.rresp = rd_err ? `IEB_RESP_SLVERR : `IEB_RESP_OKAY;
                    n.rst   = ieb_pkg::RD_RESP;
                end
            end
            ieb_pkg::RD_RESP: begin
                if (rready) begin
                    n.rst = ieb_pkg::RD_IDLE;
                end
            end
            default: n.rst = ieb_pkg::RD_IDLE;
        endcase
    end

    // State register.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s <= '0;
        end else begin
            s <= n;
        end
    end
endmodule
`default_nettype wire

// ==== logic/ieb_gate.sv ====
// Per-group request gate: flag and enable and a live priority make a request.
`timescale 1ns/1ps
`default_nettype none
`include "ieb_cfg.svh"
module ieb_gate (
    input  wire logic [15:0]      flag,
    input  wire logic [15:0]      en,
    input  wire logic [15:0][2:0] prio,
    output logic [15:0]           live,
    output logic [15:0]           req
);
    // One gate per source; a zero priority kills the source whatever its enable says.
    for (genvar i = 0; i < 16; i++) begin : g_src
        assign live[i] = (prio[i] != `IEB_PRIO_OFF);
        assign req[i]  = flag[i] & en[i] & live[i];
    end
endmodule
`default_nettype wire

// ==== logic/ieb_top.sv ====
// Interrupt enable bank: enable, flag and priority registers behind an AXI4-Lite slave.
`timescale 1ns/1ps
`default_nettype none
`include "ieb_cfg.svh"
// Notes on behaviour
// [RULE1] Set enable bit passes its source's request.
// [RULE2] Unimplemented enable bits always read zero.
// [RULE3] Enable bits read/write, reset to zero.
// [RULE4] External pins need remapping by software first.
// [RULE5] Group zero upper byte source assignment.
// [RULE6] Group zero lower byte source assignment.
// [RULE7] Group one upper byte source assignment.
// [RULE8] Group one lower byte source assignment.
// [RULE9] Group two upper byte source assignment.
// [RULE10] Group two lower byte source assignment.
// [RULE11] Source event sets its sticky flag.
// [RULE12] Priority zero disables source despite enable.
// [RULE13] Writes to unimplemented bits are dropped.
// [RULE14] Request equals flag AND enable.
module ieb_top (
    input  wire logic             aclk,
    input  wire logic             aresetn,
    input  wire logic             awvalid,
    output logic                  awready,
    input  wire logic [7:0]       awaddr,
    input  wire logic             wvalid,
    output logic                  wready,
    input  wire logic [31:0]      wdata,
    input  wire logic [3:0]       wstrb,
    output logic                  bvalid,
    input  wire logic             bready,
    output logic [1:0]            bresp,
    input  wire logic             arvalid,
    output logic                  arready,
    input  wire logic [7:0]       araddr,
    output logic                  rvalid,
    input  wire logic             rready,
    output logic [31:0]           rdata,
    output logic [1:0]            rresp,
    input  wire ieb_pkg::ieb_g0_t src_evt_g0,
    input  wire ieb_pkg::ieb_g1_t src_evt_g1,
    input  wire ieb_pkg::ieb_g2_t src_evt_g2,
    output ieb_pkg::ieb_g0_t      cpu_req_g0,
    output ieb_pkg::ieb_g1_t      cpu_req_g1,
    output ieb_pkg::ieb_g2_t      cpu_req_g2,
    output logic [2:0]            cpu_req_prio,
    output logic                  irq
);
    localparam logic [47:0] IMPL_ALL = {`IEB_IMPL_G2, `IEB_IMPL_G1, `IEB_IMPL_G0};

    ieb_pkg::ieb_core_t s;
    ieb_pkg::ieb_core_t n;
    ieb_pkg::ieb_wr_t   wr_req;
    ieb_pkg::ieb_rd_t   rd_req;
    ieb_pkg::ieb_sel_t  wsel;
    ieb_pkg::ieb_sel_t  rsel;
    logic               wr_err;
    logic               rd_err;
    logic [31:0]        rd_data;
    logic [2:0][15:0]   gate_q;
    logic [2:0][15:0]   gate_live;
    logic [2:0][15:0]   src_all;
    logic [2:0]         grp_any;
    logic [2:0]         grp_rise;
    logic               bad_access;

    // Map a byte address onto a register kind and index; used for both reads and writes.
    function automatic ieb_pkg::ieb_sel_t ieb_decode(input logic [7:0] a);
        ieb_pkg::ieb_sel_t d;
        logic [7:0]        o;
        d.kind = ieb_pkg::SEL_NONE;
        d.idx  = 4'h0;
        o      = a - `IEB_OFF_EN;
        if (o < `IEB_SPAN_EN) begin
            d.kind = ieb_pkg::SEL_EN;
            d.idx  = o[5:2];
        end
        o = a - `IEB_OFF_FLAG;
        if (o < `IEB_SPAN_FLAG) begin
            d.kind = ieb_pkg::SEL_FLAG;
            d.idx  = o[5:2];
        end
        o = a - `IEB_OFF_PRIO;
        if (o < `IEB_SPAN_PRIO) begin
            d.kind = ieb_pkg::SEL_PRIO;
            d.idx  = o[5:2];
        end
        if ({a[7:2], 2'h0} == `IEB_OFF_STATUS) begin
            d.kind = ieb_pkg::SEL_STATUS;
        end
        if ({a[7:2], 2'h0} == `IEB_OFF_MASK) begin
            d.kind = ieb_pkg::SEL_MASK;
        end
        return d;
    endfunction

    // Implemented-bit mask of one enable or flag group.
    function automatic logic [15:0] impl_of(input logic [1:0] g);
        case (g)
            2'h0:    return `IEB_IMPL_G0;
            2'h1:    return `IEB_IMPL_G1;
            2'h2:    return `IEB_IMPL_G2;
            default: return 16'h0000;
        endcase
    endfunction

    // Byte-lane merge of a 16-bit register; strobes for the upper word lanes have nothing to hit.
    function automatic logic [15:0] merge16(input logic [15:0] o, input logic [31:0] d, input logic [3:0] st);
        return {st[1] ? d[15:8] : o[15:8], st[0] ? d[7:0] : o[7:0]};
    endfunction

    // Highest live priority among the requests going to the processor.
    function automatic logic [2:0] top_prio(input logic [47:0] q, input logic [47:0][2:0] p);
        logic [2:0] best;
        best = `IEB_PRIO_OFF;
        for (int k = 0; k < 48; k++) begin
            if (q[k] && (p[k] > best)) begin
                best = p[k];
            end
        end
        return best;
    endfunction

    ieb_axil_slave u_bus (
        .aclk    (aclk),
        .aresetn (aresetn),
        .awvalid (awvalid),
        .awready (awready),
        .awaddr  (awaddr),
        .wvalid  (wvalid),
        .wready  (wready),
        .wdata   (wdata),
        .wstrb   (wstrb),
        .bvalid  (bvalid),
        .bready  (bready),
        .bresp   (bresp),
        .arvalid (arvalid),
        .arready (arready),
        .araddr  (araddr),
        .rvalid  (rvalid),
        .rready  (rready),
        .rdata   (rdata),
        .rresp   (rresp),
        .wr_req  (wr_req),
        .wr_err  (wr_err),
        .rd_req  (rd_req),
        .rd_data (rd_data),
        .rd_err  (rd_err)
    );

    // One gate per group; each bit is flag AND enable AND live priority.
    for (genvar g = 0; g < 3; g++) begin : g_grp
        ieb_gate u_gate (
            .flag (s.flag[g]),
            .en   (s.en[g]),
            .prio (s.prio[g*16 +: 16]),
            .live (gate_live[g]),
            .req  (gate_q[g])
        );
        assign grp_any[g] = |gate_q[g];
    end

    // Decode and event terms.
    assign wsel       = ieb_decode(wr_req.addr);
    assign rsel       = ieb_decode(rd_req.addr);
    assign wr_err     = (wsel.kind == ieb_pkg::SEL_NONE);
    assign rd_err     = (rsel.kind == ieb_pkg::SEL_NONE);
    assign src_all    = {src_evt_g2, src_evt_g1, src_evt_g0};
    assign grp_rise   = grp_any & ~s.grp_prev;
    assign bad_access = (wr_req.valid && wr_err) || (rd_req.valid && rd_err);

    // Request outputs are registered and irq is decoded from registered status and mask; the group structs fix which bit belongs to which source.
    assign cpu_req_g0   = ieb_pkg::ieb_g0_t'(s.req[0]); // [RULE5] [RULE6]
    assign cpu_req_g1   = ieb_pkg::ieb_g1_t'(s.req[1]); // [RULE7] [RULE8]
    assign cpu_req_g2   = ieb_pkg::ieb_g2_t'(s.req[2]); // [RULE9] [RULE10]
    assign cpu_req_prio = s.prio_top;
    assign irq          = |(s.status & s.mask);

    // Read data; unimplemented and reserved bits come back as zero.
    always_comb begin
        rd_data = 32'h0000_0000;
        case (rsel.kind)
            ieb_pkg::SEL_EN:     rd_data[15:0] = s.en[rsel.idx[1:0]] & impl_of(rsel.idx[1:0]); // [RULE2] [RULE3]
            ieb_pkg::SEL_FLAG:   rd_data[15:0] = s.flag[rsel.idx[1:0]];
            ieb_pkg::SEL_PRIO: begin
                for (int f = 0; f < 4; f++) begin
                    if (IMPL_ALL[{rsel.idx, f[1:0]}]) begin
                        rd_data[4*f +: 3] = s.prio[{rsel.idx, f[1:0]}];
                    end
                end
            end
            ieb_pkg::SEL_STATUS: rd_data[3:0] = s.status;
            ieb_pkg::SEL_MASK:   rd_data[3:0] = s.mask;
            default:             rd_data = 32'h0000_0000;
        endcase
    end

    // Next state of the bank.
    always_comb begin
        n          = s;
        n.req      = gate_q; // [RULE1] [RULE12] [RULE14]
        n.prio_top = top_prio(gate_q, s.prio);
        n.grp_prev = grp_any;
        // Software writes; only implemented positions ever take a value.
        if (wr_req.valid) begin
            case (wsel.kind)
                ieb_pkg::SEL_EN: begin
                    n.en[wsel.idx[1:0]] = merge16(s.en[wsel.idx[1:0]], wr_req.data, wr_req.strb)
                                          & impl_of(wsel.idx[1:0]); // [RULE3] [RULE13]
                end
                ieb_pkg::SEL_FLAG: begin
                    n.flag[wsel.idx[1:0]] = merge16(s.flag[wsel.idx[1:0]], wr_req.data, wr_req.strb)
                                            & impl_of(wsel.idx[1:0]);
                end
                ieb_pkg::SEL_PRIO: begin
                    for (int f = 0; f < 4; f++) begin
                        if (IMPL_ALL[{wsel.idx, f[1:0]}] && wr_req.strb[f/2]) begin
                            n.prio[{wsel.idx, f[1:0]}] = wr_req.data[4*f +: 3];
                        end
                    end
                end
                ieb_pkg::SEL_MASK: begin
                    if (wr_req.strb[0]) begin
                        n.mask = wr_req.data[3:0];
                    end
                end
                default: n.mask = s.mask;
            endcase
        end
        // Source events are ORed in after the write so that a set beats a clear in the same cycle.
        n.flag = n.flag | (src_all & IMPL_ALL); // [RULE11]
        // Status clears on read, but an event in that very cycle still lands.
        if (rd_req.valid && (rsel.kind == ieb_pkg::SEL_STATUS)) begin
            n.status = `IEB_STATUS_RST;
        end
        n.status[2:0]             = n.status[2:0] | grp_rise;
        n.status[`IEB_ST_BADADDR] = n.status[`IEB_ST_BADADDR] | bad_access;
    end

    // State register.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s        <= '0;
            s.en     <= {3{`IEB_EN_RST}};
            s.flag   <= {3{`IEB_FLAG_RST}};
            s.prio   <= {48{`IEB_PRIO_RST}};
            s.status <= `IEB_STATUS_RST;
            s.mask   <= `IEB_MASK_RST;
        end else begin
            s <= n;
        end
    end

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    property p_req_needs_en;
        ((s.req & ~$past(s.en)) == 48'h0);
    endproperty
    a_req_needs_en: assert property (p_req_needs_en) else $error("request without enable"); // [RULE1]

    property p_unimpl_zero;
        ((s.en & ~IMPL_ALL) == 48'h0) && (!rvalid || (rdata[31:16] == 16'h0000));
    endproperty
    a_unimpl_zero: assert property (p_unimpl_zero) else $error("unimplemented bit not zero"); // [RULE2]

    property p_en_reset;
        $past(!aresetn) |-> (s.en == 48'h0) && (s.req == 48'h0);
    endproperty
    a_en_reset: assert property (p_en_reset) else $error("enable not clear after reset"); // [RULE3]

    property p_adc;
        s.en[0][`IEB_POS_ADC_DONE] && s.flag[0][`IEB_POS_ADC_DONE] && gate_live[0][`IEB_POS_ADC_DONE]
            |=> cpu_req_g0.adc_done_en;
    endproperty
    a_adc: assert property (p_adc) else $error("conversion request lost"); // [RULE5]

    property p_ext_a;
        s.en[0][`IEB_POS_EXT_PIN_A] && s.flag[0][`IEB_POS_EXT_PIN_A] && gate_live[0][`IEB_POS_EXT_PIN_A]
            |=> cpu_req_g0.ext_pin_a_en;
    endproperty
    a_ext_a: assert property (p_ext_a) else $error("external pin request lost"); // [RULE6]

    property p_uart_b_tx;
        !s.en[1][`IEB_POS_UART_B_TX] |=> !cpu_req_g1.uart_b_tx_en;
    endproperty
    a_uart_b_tx: assert property (p_uart_b_tx) else $error("disabled transmit request passed"); // [RULE7]

    property p_capture_h;
        s.en[1][`IEB_POS_CAPTURE_H] && s.flag[1][`IEB_POS_CAPTURE_H] && gate_live[1][`IEB_POS_CAPTURE_H]
            |=> cpu_req_g1.capture_h_en;
    endproperty
    a_capture_h: assert property (p_capture_h) else $error("capture request lost"); // [RULE8]

    property p_pport;
        !s.flag[2][`IEB_POS_PARALLEL_PORT] |=> !cpu_req_g2.parallel_port_en;
    endproperty
    a_pport: assert property (p_pport) else $error("parallel port request without flag"); // [RULE9]

    property p_spi_b_fault;
        s.en[2][`IEB_POS_SPI_B_FAULT] && s.flag[2][`IEB_POS_SPI_B_FAULT] && gate_live[2][`IEB_POS_SPI_B_FAULT]
            |=> cpu_req_g2.spi_b_fault_en;
    endproperty
    a_spi_b_fault: assert property (p_spi_b_fault) else $error("fault request lost"); // [RULE10]

    property p_flag_set;
        $past(aresetn) |-> ((s.flag & $past(src_all) & IMPL_ALL) == ($past(src_all) & IMPL_ALL));
    endproperty
    a_flag_set: assert property (p_flag_set) else $error("source event did not set flag"); // [RULE11]

    property p_prio_off;
        ((s.req & ~$past(gate_live)) == 48'h0);
    endproperty
    a_prio_off: assert property (p_prio_off) else $error("request at priority zero"); // [RULE12]

    property p_en_write;
        wr_req.valid && (wsel.kind == ieb_pkg::SEL_EN) && (wsel.idx == 4'h0) && (wr_req.strb[1:0] == 2'h3)
            |=> s.en[0] == ($past(wr_req.data[15:0]) & `IEB_IMPL_G0);
    endproperty
    a_en_write: assert property (p_en_write) else $error("enable write not taken as masked"); // [RULE13]

    property p_req_and;
        (s.flag[1] & s.en[1] & gate_live[1]) != 16'h0000 |=> (s.req[1] != 16'h0000) && (s.prio_top != 3'h0);
    endproperty
    a_req_and: assert property (p_req_and) else $error("flag and enable gave no request"); // [RULE14]

    // Request vector and top priority are registered on the same edge, so they are checked together.
    property p_prio_idle;
        (s.req == 48'h0) |-> (s.prio_top == 3'h0);
    endproperty
    a_prio_idle: assert property (p_prio_idle) else $error("priority shown with no request"); // [RULE12]

    property p_en_hold;
        !(wr_req.valid && (wsel.kind == ieb_pkg::SEL_EN)) |=> $stable(s.en);
    endproperty
    a_en_hold: assert property (p_en_hold) else $error("enable changed without a write"); // [RULE3]

    c_req_out: cover property (wr_req.valid && (wsel.kind == ieb_pkg::SEL_EN) ##[1:20] (s.req != 48'h0));
    c_irq: cover property ($rose(irq));
    c_status_rc: cover property (rd_req.valid && (rsel.kind == ieb_pkg::SEL_STATUS) && (s.status != 4'h0));
    c_bad: cover property (bvalid && (bresp == `IEB_RESP_SLVERR));
endmodule
`default_nettype wire

// ==== verification/ieb_src_model.sv ====
// Model of the peripheral request sources that face the enable bank.
`timescale 1ns/1ps
`default_nettype none
module ieb_src_model (
    input  wire logic [47:0]      pat,
    input  wire logic             go,
    output wire ieb_pkg::ieb_g0_t evt_g0,
    output wire ieb_pkg::ieb_g1_t evt_g1,
    output wire ieb_pkg::ieb_g2_t evt_g2
);
    // Request lines idle low and pulse for one cycle; external pin inputs count as routed already.
    assign {evt_g2, evt_g1, evt_g0} = go ? pat : 48'h0;
endmodule
`default_nettype wire

// ==== verification/test_interrupt_enable_bank.sv ====
// Self-checking bench for the interrupt enable bank.
`timescale 1ns/1ps
`default_nettype none
module test_interrupt_enable_bank;
    logic             aclk = 0, aresetn = 0, go = 0;
    logic             awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
    logic [7:0]       awaddr = '0, araddr = '0;
    logic [31:0]      wdata = '0, rdata, rd_v;
    logic [3:0]       wstrb = '0;
    logic [1:0]       bresp, rresp, rsp;
    logic             awready, wready, bvalid, arready, rvalid, irq;
    logic [2:0]       cpu_req_prio;
    logic [47:0]      pat = '0;
    logic [2:0][15:0] q;
    ieb_pkg::ieb_g0_t e0, q0;
    ieb_pkg::ieb_g1_t e1, q1;
    ieb_pkg::ieb_g2_t e2, q2;
    int               error_cnt = 0, tests_run = 0;
    localparam logic [15:0] impl_mask [3] = '{16'h3fef, 16'hfedf, 16'h3fe3};
    localparam logic [15:0] pat_tab [2] = '{16'haaaa, 16'h5555};

    // Clock and the request vector gathered per group.
    always #50 aclk = ~aclk;
    assign q = {q2, q1, q0};

    ieb_top dut (.aclk(aclk), .aresetn(aresetn), .awvalid(awvalid), .awready(awready), .awaddr(awaddr),
        .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb), .bvalid(bvalid), .bready(bready),
        .bresp(bresp), .arvalid(arvalid), .arready(arready), .araddr(araddr), .rvalid(rvalid),
        .rready(rready), .rdata(rdata), .rresp(rresp), .src_evt_g0(e0), .src_evt_g1(e1), .src_evt_g2(e2),
        .cpu_req_g0(q0), .cpu_req_g1(q1), .cpu_req_g2(q2), .cpu_req_prio(cpu_req_prio), .irq(irq));
    ieb_src_model src (.pat(pat), .go(go), .evt_g0(e0), .evt_g1(e1), .evt_g2(e2));

    task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
        tests_run++;
        if (got !== ex) begin
            error_cnt++;
            $display("[ERR] %s expected %h seen %h", nm, ex, got);
        end
    endtask

    // Write; each half is released at the edge that takes it.
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        bit ta, tw;
        ta = 0;
        tw = 0;
        awvalid <= 1;
        wvalid <= 1;
        awaddr <= a;
        wdata <= d;
        wstrb <= 4'hf;
        bready <= 1;
        while (!(ta && tw)) begin
            @(posedge aclk);
            if (!ta && awready) begin
                ta = 1;
                awvalid <= 0;
            end
            if (!tw && wready) begin
                tw = 1;
                wvalid <= 0;
            end
        end
        do @(posedge aclk); while (!bvalid);
        rsp = bresp;
        bready <= 0;
        @(posedge aclk);
    endtask

    task automatic rd(input logic [7:0] a);
        arvalid <= 1;
        araddr <= a;
        rready <= 1;
        do @(posedge aclk); while (!arready);
        arvalid <= 0;
        do @(posedge aclk); while (!rvalid);
        rd_v = rdata;
        rsp = rresp;
        rready <= 0;
        @(posedge aclk);
    endtask

    // One-cycle pulse on the chosen source lines, then time for the request to settle.
    task automatic fire(input logic [47:0] p);
        pat <= p;
        go <= 1;
        @(posedge aclk);
        go <= 0;
        repeat (4) @(posedge aclk);
    endtask

    task automatic t_reset;
        for (int g = 0; g < 3; g++) begin
            rd(8'(4 * g));
            chk("enable reset", 32'h0, rd_v);
        end
        chk("irq reset", 32'h0, {31'h0, irq});
        $display("test reset done");
    endtask

    task automatic t_rw;
        for (int g = 0; g < 3; g++) begin
            wr(8'(4 * g), 32'hffffffff);
            rd(8'(4 * g));
            chk("enable ones", {16'h0, impl_mask[g]}, rd_v);
            wr(8'(4 * g), 32'h0);
            rd(8'(4 * g));
            chk("enable zeros", 32'h0, rd_v);
        end
        $display("test read write done");
    endtask

    // Alternating patterns make a swapped or shifted bit show up.
    task automatic t_gate;
        for (int g = 0; g < 3; g++) begin
            for (int k = 0; k < 2; k++) begin
                wr(8'(4 * g), {16'h0, pat_tab[k]});
                fire({3{16'hffff}});
                chk("request", {16'h0, pat_tab[k] & impl_mask[g]}, {16'h0, q[g]});
                rd(8'(16 + 4 * g));
                chk("flag", {16'h0, impl_mask[g]}, rd_v);
                wr(8'(16 + 4 * g), 32'h0);
            end
        end
        $display("test gate done");
    endtask

    task automatic t_prio;
        wr(8'h00, 32'hffff);
        wr(8'h20, 32'h0);
        fire({3{16'hffff}});
        chk("prio zero", {16'h0, impl_mask[0] & 16'hfff0}, {16'h0, q[0]});
        wr(8'h20, 32'h4474);
        repeat (3) @(posedge aclk);
        chk("prio back", {16'h0, impl_mask[0]}, {16'h0, q[0]});
        chk("top prio", 32'h7, {29'h0, cpu_req_prio});
        $display("test priority done");
    endtask

    task automatic t_irq;
        rd(8'h50);
        wr(8'h54, 32'h8);
        rd(8'h60);
        chk("unmapped resp", 32'h2, {30'h0, rsp});
        chk("unmapped data", 32'h0, rd_v);
        repeat (2) @(posedge aclk);
        chk("irq on", 32'h1, {31'h0, irq});
        wr(8'h54, 32'h0);
        chk("irq masked", 32'h0, {31'h0, irq});
        wr(8'h60, 32'h1);
        chk("unmapped write", 32'h2, {30'h0, rsp});
        wr(8'h54, 32'h8);
        rd(8'h50);
        chk("status", 32'h8, rd_v);
        repeat (2) @(posedge aclk);
        chk("irq cleared", 32'h0, {31'h0, irq});
        $display("test interrupt done");
    endtask

    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // Main sequence after three cycles of reset.
    initial begin
        repeat (3) @(posedge aclk);
        aresetn <= 1;
        @(posedge aclk);
        t_reset;
        t_rw;
        t_gate;
        t_prio;
        t_irq;
        tally_and_finish;
    end

    // The tests need well under a thousand cycles; five thousand means a hang.
    initial begin
        #(5000 * 100);
        error_cnt++;
        tally_and_finish;
    end
endmodule
`default_nettype wire
